// [verilog/fsc_fanout_serial_config.sv]
/*
  Serial programming logic of a 1:10 clock fanout: shift chain, sequencer
  and control register, plus the output gating and input selection.
  Assumes progClock is the link clock from the host; mclk is the system
  clock on which the resulting gate and select levels are presented.
  Pull resistors are modelled by the pad ring, seen here as defaults.
*/
// How it works
// RULE1: serial data is shifted only on a progClock rise while enable is high.
// RULE2: open pins read enable and data low and the programming clock high.
// RULE3: with enable low all outputs are on and the data level picks input.
// RULE4: enable low resets the sequencer, shift chain and control register.
// RULE5: each shift puts data in stage 0 and moves every stage up by one.
// RULE6: host sends bit 0 first; bit 0 gates output nine, bit 10 selects.
// RULE7: the twelfth pulse copies the shift chain into the control register.
// RULE8: an enable rise clears the control register and starts a sequence.
// RULE9: in programmed mode bit 10 low picks input a, high picks input b.
// RULE10: enabled pairs follow the chosen input, inverted side opposite.
// RULE11: the host holds enable high through all programming pulses.
// RULE12: without programming the block runs in the default mode.
// RULE13: a control bit high enables its pair, low puts it in high impedance (here fanoutOe low and both sides driven low).
// RULE14: after the load, further pulses leave the register unchanged.
`timescale 1ns/1ps
`default_nettype none
`include "fsc_regs.svh"

module fsc_fanout_serial_config (
  input  wire logic            mclk,
  input  wire logic            sys_rst,
  input  wire logic            progClock,
  input  wire logic            progEnable,
  input  wire logic            serialData,
  input  wire logic            clock_input_a,
  input  wire logic            clock_input_b,
  output logic [9:0]           fanout_outputs,
  output logic [9:0]           fanout_outputs_n,
  output logic [9:0]           fanoutOe,
  output logic                 inputSelect,
  output logic                 programmed
);
  import fsc_pkg::*;

  // Link domain: enable low is an asynchronous clear of the sequencer
  wire logic progRstN = progEnable; // [RULE4] [RULE11]

  fsc_cfg_t   shift_r;
  fsc_cfg_t   ctrl_r;
  fsc_state_t state_r;
  fsc_state_t state_nxt;
  logic [`FSC_CNT_W-1:0] count_r;
  logic [`FSC_CNT_W-1:0] count_nxt;

  // Link side decode, kept as named wires
  wire logic lastData  = (count_r == `FSC_CNT_LOADED);
  wire logic notLoaded = (state_r != FSC_LOADED);
  wire logic shiftEn   = notLoaded & ~lastData; // [RULE1]
  wire logic loadEn    = notLoaded & lastData;  // [RULE7] [RULE14]

  wire fsc_cfg_t shiftNxt = {shift_r[`FSC_CFG_BITS-2:0], serialData}; // [RULE5]

  // Stage 0 ends up with the last bit sent, so the chain is mirrored
  // on load; the control register then carries the bit numbers the
  // host uses, bit 10 being the input select [RULE6]
  function automatic fsc_cfg_t orderCfg(input fsc_cfg_t s);
    fsc_cfg_t r;
    r = '0;
    for (int i = 0; i < `FSC_CFG_BITS; i++) begin
      r[i] = s[`FSC_CFG_BITS-1-i];
    end
    return r;
  endfunction

  wire fsc_cfg_t loadNxt = orderCfg(shift_r); // [RULE6]

  always_comb begin
    state_nxt = state_r;
    count_nxt = count_r;
    case (state_r)
      FSC_IDLE, FSC_SHIFT: begin
        if (lastData) begin
          state_nxt = FSC_LOADED; // [RULE7]
        end else begin
          state_nxt = FSC_SHIFT;
          count_nxt = count_r + 4'h1;
        end
      end
      FSC_LOADED: state_nxt = FSC_LOADED; // [RULE14]
      default: state_nxt = FSC_IDLE;
    endcase
  end

  // Enable rising releases the clear, so each sequence starts clean
  always_ff @(posedge progClock or negedge progRstN) begin
    if (!progRstN) begin // [RULE4] [RULE8]
      state_r <= FSC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge progClock or negedge progRstN) begin
    if (!progRstN) begin // [RULE4]
      count_r <= 4'h0;
    end else begin
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge progClock or negedge progRstN) begin
    if (!progRstN) begin // [RULE4]
      shift_r <= `FSC_CTRL_RESET;
    end else if (shiftEn) begin
      shift_r <= shiftNxt; // [RULE1] [RULE5]
    end
  end

  // Written once per sequence, then left alone [RULE14]
  always_ff @(posedge progClock or negedge progRstN) begin
    if (!progRstN) begin // [RULE4] [RULE8]
      ctrl_r <= `FSC_CTRL_RESET;
    end else if (loadEn) begin
      ctrl_r <= loadNxt; // [RULE7]
    end
  end

  // Loaded flag: a level that rises once per sequence
  wire logic loaded = ~notLoaded;

  // Pins and the loaded flag cross into mclk through two flops each;
  // only the second flop of each pair is read further on
  logic [1:0] enSync_r;
  logic [1:0] sdSync_r;
  logic [1:0] ldSync_r;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      enSync_r <= 2'h0; // [RULE2]
    end else begin
      enSync_r <= {enSync_r[0], progEnable};
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sdSync_r <= 2'h0; // [RULE2]
    end else begin
      sdSync_r <= {sdSync_r[0], serialData};
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ldSync_r <= 2'h0;
    end else begin
      ldSync_r <= {ldSync_r[0], loaded};
    end
  end

  // The control word is copied once, one edge after the loaded flag
  // has crossed, when it has been still for two edges. Reading it
  // live would let the clear on enable low reach the outputs before
  // the mode change does.
  logic     ldSeen_r;
  fsc_cfg_t ctrlCopy_r;
  wire logic ldRise = ldSync_r[1] & ~ldSeen_r;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ldSeen_r <= 1'b0;
    end else begin
      ldSeen_r <= ldSync_r[1];
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      ctrlCopy_r <= `FSC_CTRL_RESET;
    end else if (ldRise) begin
      ctrlCopy_r <= ctrl_r; // [RULE7] [RULE14]
    end
  end

  // Programmed only once the copy is valid
  wire logic progMode = enSync_r[1] & ldSeen_r;
  // Enable high but not yet loaded: register cleared, outputs off [RULE8]
  wire logic cleared  = enSync_r[1] & ~ldSeen_r;

  // Bit 0 gates output nine: reverse the ten gate bits [RULE6]
  function automatic fsc_gate_t reverseGate(input fsc_cfg_t c);
    fsc_gate_t g;
    g = '0;
    for (int i = 0; i < `FSC_NUM_OUTPUTS; i++) begin
      g[i] = c[`FSC_NUM_OUTPUTS-1-i];
    end
    return g;
  endfunction

  wire fsc_gate_t progGate = reverseGate(ctrlCopy_r); // [RULE6] [RULE13]
  wire logic      progSel  = ctrlCopy_r[`FSC_SEL_BIT]; // [RULE9]

  wire fsc_gate_t gateNxt = progMode ? progGate :
                            cleared  ? 10'h000 : 10'h3FF; // [RULE3] [RULE13]
  wire logic selNxt = progMode ? progSel :
                      cleared  ? 1'b0 : sdSync_r[1]; // [RULE3] [RULE9] [RULE12]

  fsc_gate_t gate_r;
  logic      sel_r;
  logic      prog_r;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      gate_r <= 10'h3FF; // [RULE12]
    end else begin
      gate_r <= gateNxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sel_r <= 1'b0;
    end else begin
      sel_r <= selNxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      prog_r <= 1'b0;
    end else begin
      prog_r <= progMode;
    end
  end

  assign fanoutOe    = gate_r; // [RULE13]
  assign inputSelect = sel_r;
  assign programmed  = prog_r;

  // Clock path is a mux, not sampled: it models the analog fanout
  wire logic srcClk = sel_r ? clock_input_b : clock_input_a; // [RULE9]
  assign fanout_outputs   = gate_r & {10{srcClk}};  // [RULE10]
  assign fanout_outputs_n = gate_r & {10{~srcClk}}; // [RULE10]

endmodule // fsc_fanout_serial_config

`default_nettype wire

// [verilog/fsc_regs.svh]
/*
  Constants of the fanout serial configuration block: field positions,
  counts and reset values. Definitions only.
*/
`ifndef FSC_REGS_SVH
`define FSC_REGS_SVH

`define FSC_NUM_OUTPUTS   10
`define FSC_CFG_BITS      11
`define FSC_SEL_BIT       10
`define FSC_LOAD_PULSE    12
`define FSC_CNT_W         4
`define FSC_CTRL_RESET    11'h000
`define FSC_CNT_LOADED    4'hB

`endif

// [verilog/fsc_pkg.sv]
/*
  Types of the fanout serial configuration block.
  Assumes fsc_regs.svh is on the include path.
*/
`include "fsc_regs.svh"
package fsc_pkg;
  typedef logic [`FSC_CFG_BITS-1:0]    fsc_cfg_t;
  typedef logic [`FSC_NUM_OUTPUTS-1:0] fsc_gate_t;
  typedef enum logic [1:0] {
    FSC_IDLE    = 2'b00,
    FSC_SHIFT   = 2'b01,
    FSC_LOADED  = 2'b10
  } fsc_state_t;
endpackage

// [testbench/fsc_host_model.sv]
/* Host model driving the programming pins.
   Assumes the bench calls one task at a time. */
`timescale 1ns/1ps
`default_nettype none
module fsc_host_model (
  output logic progClock,
  output logic progEnable,
  output logic serialData
);
  initial {progClock, progEnable, serialData} = 3'h4;
  // Clock idles high between frames; data moves on the fall
  task automatic send(input logic [10:0] c, input int a, input int b);
    progEnable = 1'b1;
    #23;
    for (int i = a; i < b; i++) begin
      #7.5 progClock = 1'b0;
      serialData = (i < 11) ? c[i] : ~serialData;
      #7.5 progClock = 1'b1;
    end
    #5 serialData = 1'b0;
  endtask
  task automatic idle(input logic s);
    progEnable = 1'b0;
    serialData = s;
  endtask
endmodule // fsc_host_model
`default_nettype wire

// [testbench/fsc_checker_properties.sv]
/* Checker on the top ports of the serial config block.
   Assumes outputs lag the pins by at most 4 mclk edges. */
`timescale 1ns/1ps
`default_nettype none
module fsc_checker (
  input wire logic       mclk,
  input wire logic       sys_rst,
  input wire logic       progEnable,
  input wire logic       serialData,
  input wire logic       clock_input_a,
  input wire logic       clock_input_b,
  input wire logic [9:0] fanout_outputs,
  input wire logic [9:0] fanout_outputs_n,
  input wire logic [9:0] fanoutOe,
  input wire logic       inputSelect,
  input wire logic       programmed
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  wire logic pick = inputSelect ? clock_input_b : clock_input_a;
  sequence idleS; !progEnable [*5]; endsequence
  sequence armS; progEnable [*5] ##0 !programmed; endsequence
  pos_side_a: assert property (fanout_outputs == (fanoutOe & {10{pick}}))
    else $error("true side wrong");
  neg_side_a: assert property (fanout_outputs_n == (fanoutOe & ~{10{pick}}))
    else $error("inverted side wrong");
  default_on_a: assert property (idleS |-> fanoutOe == 10'h3FF && !programmed)
    else $error("default gates wrong");
  default_sel_a: assert property ((!progEnable && $stable(serialData)) [*5] |-> inputSelect == serialData)
    else $error("default select wrong");
  arm_clear_a: assert property (armS |-> fanoutOe == 10'h000 && !inputSelect)
    else $error("not cleared");
  load_hold_a: assert property (programmed && $past(programmed) |-> $stable(fanoutOe) && $stable(inputSelect))
    else $error("loaded value moved");
  drop_clear_a: assert property ($fell(progEnable) |-> ##[1:6] !programmed)
    else $error("drop ignored");
  load_en_a: assert property ($rose(programmed) |-> $past(progEnable, 6))
    else $error("load without enable");
endmodule // fsc_checker
bind fsc_fanout_serial_config fsc_checker chk (.mclk, .sys_rst, .progEnable,
  .serialData, .clock_input_a, .clock_input_b, .fanout_outputs,
  .fanout_outputs_n, .fanoutOe, .inputSelect, .programmed);
`default_nettype wire

// [testbench/fsc_fanout_serial_config_tb.sv]
/* Bench of the serial config block with host model and bound checker.
   Assumes the host model drives the three programming pins. */
`timescale 1ns/1ps
`default_nettype none
module fsc_fanout_serial_config_tb;
  import fsc_pkg::*;
  logic mclk = 1'b0, sys_rst = 1'b1, clock_input_a = 1'b0, clock_input_b = 1'b0;
  logic [31:0] seed = 32'h24;
  int error_cnt = 0, compares = 0;
  wire logic progClock, progEnable, serialData;
  fsc_gate_t fanout_outputs, fanout_outputs_n, fanoutOe;
  logic inputSelect, programmed;
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic fsc_gate_t expOe(input logic [9:0] c);
    for (int i = 0; i < 10; i++) expOe[i] = c[9 - i];
  endfunction
  always #5 mclk = ~mclk;
  always @(posedge mclk) {clock_input_a, clock_input_b} <= 2'(rnd());
  fsc_fanout_serial_config DUT (.mclk, .sys_rst, .progClock, .progEnable,
    .serialData, .clock_input_a, .clock_input_b, .fanout_outputs,
    .fanout_outputs_n, .fanoutOe, .inputSelect, .programmed);
  fsc_host_model host (.progClock, .progEnable, .serialData);
  task automatic check(input logic [11:0] e);
    repeat (8) @(posedge mclk);
    #1 compares++;
    if ({programmed, inputSelect, fanoutOe} !== e) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time,
               {programmed, inputSelect, fanoutOe}, e);
    end
  endtask
  task automatic print_verdict();
    $display("compares=%0d errors=%0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    logic [10:0] c;
    repeat (4) @(posedge mclk);
    sys_rst <= 1'b0;
    check({2'b00, 10'h3FF});
    host.idle(1'b1);
    check({2'b01, 10'h3FF});
    for (int t = 0; t < 6; t++) begin
      c = t == 0 ? 11'h000 : t == 1 ? 11'h7FF : 11'(rnd());
      host.send(c, 0, 5);
      check({2'b00, 10'h000});
      host.send(c, 5, 12);
      check({1'b1, c[10], expOe(c[9:0])});
      host.send(~c, 0, 3);
      check({1'b1, c[10], expOe(c[9:0])});
      host.idle(t[0]);
      check({1'b0, t[0], 10'h3FF});
      $display("test %0d end cfg=%h", t, c);
    end
    print_verdict();
  end
  initial begin
    #100000;
    error_cnt++;
    print_verdict();
  end
endmodule // fsc_fanout_serial_config_tb
`default_nettype wire
